// ### rtl/led_slot_config_regs.sv
// Register bank for slot detector routing and third emitter drive settings
`timescale 1ns/1ps
`include "led_slot_consts.svh"

// Functional notes
// - Slot B detector routing sits in bits 11:8, resets to 5; 0 floats, 1 and 5 connect, others reserved.
// - Slot A detector routing sits in bits 7:4, resets to 4, with the same codes as slot B.
// - Slot B emitter choice sits in bits 3:2, resets to 0; 0 pulses only detectors, 1-3 pick a driver.
// - Slot A emitter choice sits in bits 1:0, resets to 1, with the same encoding.
// - Third emitter bit 13 resets to 1 for full strength; cleared gives 40 percent low power.
// - Third emitter edge rate sits in bits 6:4, resets to 0, 0 slowest and 7 fastest.
// - Third emitter coarse current sits in bits 3:0, resets to 0, target 50.3 plus 19.8 per code mA.
// - Peak target is coarse times fine times scale, fine being 0.74 plus 0.022 times fine bits 15:11.
module led_slot_config_regs
   import led_slot_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // Host port register access
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   output logic [15:0]        reg_rdata,
   output logic               reg_rvalid,
   // Decoded settings to the sequencer and drivers
   output slot_routing_t      routing,
   output emitter3_cfg_t      emitter3_cfg,
   output route_status_t      route_status,
   output logic [31:0]        emitter3_peak_target
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Only these three codes leave the detector inputs in a known state
   function automatic logic route_known(input logic [3:0] code);
      route_known = (code == `ROUTE_FLOAT) || (code == `ROUTE_ALL) || (code == `ROUTE_FOUR);
   endfunction

   function automatic logic route_connects(input logic [3:0] code);
      route_connects = (code == `ROUTE_ALL) || (code == `ROUTE_FOUR);
   endfunction

   // One strobe qualified by one register address
   function automatic logic addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
      addr_hit = strobe && (addr == target);
   endfunction

   function automatic logic [3:0] route_b_field(input logic [15:0] word);
      route_b_field = word[`ROUTE_B_HI:`ROUTE_B_LO];
   endfunction

   function automatic logic [3:0] route_a_field(input logic [15:0] word);
      route_a_field = word[`ROUTE_A_HI:`ROUTE_A_LO];
   endfunction

   // Reserved codes flagged so the sequencer can leave inputs floating
   function automatic route_status_t route_flags(input logic [15:0] word);
      route_status_t flags;
      flags.connect_b   = route_connects(route_b_field(word));
      flags.connect_a   = route_connects(route_a_field(word));
      flags.route_b_bad = !route_known(route_b_field(word));
      flags.route_a_bad = !route_known(route_a_field(word));
      return flags;
   endfunction

   // ---------------------------------------------------------------
   // Slot routing register
   // ---------------------------------------------------------------
   logic [15:0]   routing_reg;
   logic [15:0]   routing_next;
   logic          routing_hit;

   assign routing_hit = addr_hit(reg_write, reg_addr, `ROUTING_ADDR);

   // Reserved top bits held at zero whatever software sends
   always_comb begin
      routing_next = routing_reg;
      if (routing_hit) begin
         routing_next = reg_wdata & `ROUTING_WMASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         routing_reg <= `ROUTING_RESET;
      end else begin
         routing_reg <= routing_next;
      end
   end

   // ---------------------------------------------------------------
   // Third emitter drive register
   // ---------------------------------------------------------------
   logic [15:0]   emitter3_reg;
   logic [15:0]   emitter3_next;
   logic          emitter3_hit;

   assign emitter3_hit = addr_hit(reg_write, reg_addr, `EMITTER3_ADDR);

   // Reserved bits forced so a careless write cannot upset the driver
   always_comb begin
      emitter3_next = emitter3_reg;
      if (emitter3_hit) begin
         emitter3_next = (reg_wdata & `EMITTER3_WMASK) | `EMITTER3_FIXED;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         emitter3_reg <= `EMITTER3_RESET;
      end else begin
         emitter3_reg <= emitter3_next;
      end
   end

   // ---------------------------------------------------------------
   // Fine adjust register
   // ---------------------------------------------------------------
   logic [15:0]   fine_reg;
   logic [15:0]   fine_next;
   logic          fine_hit;

   assign fine_hit = addr_hit(reg_write, reg_addr, `FINE_ADDR);

   // Stored whole; only the top five bits feed the peak target
   always_comb begin
      fine_next = fine_reg;
      if (fine_hit) begin
         fine_next = reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fine_reg <= `FINE_RESET;
      end else begin
         fine_reg <= fine_next;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [15:0]   rdata_reg;
   logic [15:0]   rdata_next;
   logic          rvalid_reg;
   logic          rvalid_next;

   // Data holds between reads so a slow host can pick it up late
   // A read in the cycle of a write returns the old word
   always_comb begin
      rvalid_next = reg_read;
      rdata_next  = rdata_reg;
      if (reg_read) begin
         unique case (reg_addr)
            `ROUTING_ADDR:  rdata_next = routing_reg;
            `EMITTER3_ADDR: rdata_next = emitter3_reg;
            `FINE_ADDR:     rdata_next = fine_reg;
            default:        rdata_next = `READ_EMPTY;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg  <= `READ_EMPTY;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ---------------------------------------------------------------
   // Routing status
   // ---------------------------------------------------------------
   route_status_t status_reg;
   route_status_t status_next;

   // Taken from the next routing word so the flags never lag the fields
   always_comb begin
      status_next = route_flags(routing_next);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= `STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // ---------------------------------------------------------------
   // Field outputs
   // ---------------------------------------------------------------
   always_comb begin
      routing.slot_b_detector_route = route_b_field(routing_reg);
      routing.slot_a_detector_route = route_a_field(routing_reg);
      routing.slot_b_emitter_choice = emitter_choice_t'(routing_reg[`EMIT_B_HI:`EMIT_B_LO]);
      routing.slot_a_emitter_choice = emitter_choice_t'(routing_reg[`EMIT_A_HI:`EMIT_A_LO]);
      emitter3_cfg.emitter3_strength_bit   = emitter3_reg[`STRENGTH_BIT];
      emitter3_cfg.emitter3_edge_rate      = emitter3_reg[`EDGE_HI:`EDGE_LO];
      emitter3_cfg.emitter3_coarse_current = emitter3_reg[`COARSE_HI:`COARSE_LO];
   end

   assign reg_rdata    = rdata_reg;
   assign reg_rvalid   = rvalid_reg;
   assign route_status = status_reg;

   // ---------------------------------------------------------------
   // Peak target
   // ---------------------------------------------------------------
   emitter3_peak_calc peak_calc (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .cfg         (emitter3_cfg),
      .fine_code   (fine_reg[`FINE_HI:`FINE_LO]),
      .peak_target (emitter3_peak_target)
   );
endmodule

// ### rtl/led_slot_consts.svh
// Register offsets, field positions, reset values and current arithmetic constants
`ifndef LED_SLOT_CONSTS_SVH
`define LED_SLOT_CONSTS_SVH
`define ROUTING_ADDR        8'h14
`define EMITTER3_ADDR       8'h22
`define FINE_ADDR           8'h25
`define ROUTING_RESET       16'h0541
`define EMITTER3_RESET      16'h3000
`define FINE_RESET          16'h0000
`define ROUTING_WMASK       16'h0fff
`define EMITTER3_WMASK      16'h207f
`define EMITTER3_FIXED      16'h1000
`define ROUTE_B_HI          11
`define ROUTE_B_LO          8
`define ROUTE_A_HI          7
`define ROUTE_A_LO          4
`define EMIT_B_HI           3
`define EMIT_B_LO           2
`define EMIT_A_HI           1
`define EMIT_A_LO           0
`define STRENGTH_BIT        13
`define EDGE_HI             6
`define EDGE_LO             4
`define COARSE_HI           3
`define COARSE_LO           0
`define FINE_HI             15
`define FINE_LO             11
`define ROUTE_FLOAT         4'h0
`define ROUTE_ALL           4'h1
`define ROUTE_FOUR          4'h5
// Coarse in tenths of mA: 503 + 198*code
`define COARSE_BASE         12'h1f7
`define COARSE_STEP         12'h0c6
// Fine in thousandths: 740 + 22*code
// Eleven bits: the top fine code reaches 1422
`define FINE_BASE           11'h2e4
`define FINE_STEP           11'h016
// Scale in tenths: 4 + 6*bit
`define SCALE_BASE          4'h4
`define SCALE_STEP          4'h6
// Flags of the reset routing word: slot B connected, slot A code reserved
`define STATUS_RESET        4'h9
`define READ_EMPTY          16'h0000
`define PEAK_RESET          32'h0000_0000
`endif

// ### rtl/led_slot_pkg.sv
// Types shared by the emitter and detector routing register bank
package led_slot_pkg;
   typedef enum logic [1:0] {
      EMIT_NONE,
      EMIT_ONE,
      EMIT_TWO,
      EMIT_THREE
   } emitter_choice_t;

   typedef struct packed {
      logic [3:0]      slot_b_detector_route;
      logic [3:0]      slot_a_detector_route;
      emitter_choice_t slot_b_emitter_choice;
      emitter_choice_t slot_a_emitter_choice;
   } slot_routing_t;

   typedef struct packed {
      logic       emitter3_strength_bit;
      logic [2:0] emitter3_edge_rate;
      logic [3:0] emitter3_coarse_current;
   } emitter3_cfg_t;

   typedef struct packed {
      logic        connect_b;
      logic        connect_a;
      logic        route_b_bad;
      logic        route_a_bad;
   } route_status_t;
endpackage

// ### rtl/emitter3_peak_calc.sv
// Registered peak drive target for the third emitter driver
`timescale 1ns/1ps
`include "led_slot_consts.svh"
module emitter3_peak_calc
   import led_slot_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // Settings
   input  wire emitter3_cfg_t cfg,
   input  wire logic [4:0]    fine_code,
   // Target in 1e-5 mA units
   output logic [31:0]        peak_target
);
   logic [11:0] coarse_tenths;
   logic [10:0] fine_milli;
   logic [3:0]  scale_tenths;
   logic [31:0] peak_next;
   logic [31:0] peak_reg;

   always_comb begin
      coarse_tenths = `COARSE_BASE + 12'(`COARSE_STEP * {8'h00, cfg.emitter3_coarse_current});
      fine_milli    = `FINE_BASE + 11'(`FINE_STEP * {6'h00, fine_code});
      scale_tenths  = `SCALE_BASE + (cfg.emitter3_strength_bit ? `SCALE_STEP : 4'h0);
      // Product of three fixed-point factors
      peak_next     = 32'({20'h0, coarse_tenths} * {21'h0, fine_milli} * {28'h0, scale_tenths});
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_reg <= `PEAK_RESET;
      end else begin
         peak_reg <= peak_next;
      end
   end

   assign peak_target = peak_reg;
endmodule

// ### tb/led_slot_config_regs_chk.sv
// Concurrent checks on the routing and third emitter bank
`timescale 1ns/1ps
module led_slot_config_regs_chk
   import led_slot_pkg::*;
(
   // Clock and reset
   input wire logic          sys_clk,
   input wire logic          rst_b,
   // Host port
   input wire logic          reg_write,
   input wire logic          reg_read,
   input wire logic [7:0]    reg_addr,
   input wire logic [15:0]   reg_wdata,
   input wire logic [15:0]   reg_rdata,
   input wire logic          reg_rvalid,
   // Settings
   input wire slot_routing_t routing,
   input wire emitter3_cfg_t emitter3_cfg,
   input wire route_status_t route_status,
   input wire logic [31:0]   emitter3_peak_target
);
   wire       w14 = reg_write && reg_addr == 8'h14;
   wire       w22 = reg_write && reg_addr == 8'h22;
   wire [7:0] we8 = {reg_wdata[13], reg_wdata[6:0]};
   wire [3:0] rb  = routing.slot_b_detector_route;
   wire [3:0] ra  = routing.slot_a_detector_route;
   wire       cb  = rb == 4'h1 || rb == 4'h5;
   wire       ca  = ra == 4'h1 || ra == 4'h5;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_route_load: assert property (w14 |=> routing == $past(reg_wdata[11:0]))
      else $error("routing not loaded");
   a_route_hold: assert property (!w14 |=> $stable(routing))
      else $error("routing changed without write");
   a_emit3_load: assert property (w22 |=> emitter3_cfg == $past(we8))
      else $error("emitter3 not loaded");
   a_emit3_hold: assert property (!w22 |=> $stable(emitter3_cfg))
      else $error("emitter3 changed without write");
   a_read_pulse: assert property (1'b1 |=> reg_rvalid == $past(reg_read))
      else $error("read valid timing wrong");
   a_route_read: assert property (reg_rvalid && $past(reg_addr) == 8'h14
      |-> reg_rdata == {4'h0, $past(routing)}) else $error("routing readback wrong");
   a_emit3_read: assert property (reg_rvalid && $past(reg_addr) == 8'h22
      |-> reg_rdata[15:7] == {2'b00, $past(emitter3_cfg.emitter3_strength_bit), 6'h20})
      else $error("emitter3 readback wrong");
   a_route_stat: assert property (route_status == {cb, ca, !cb && rb != 4'h0, !ca && ra != 4'h0})
      else $error("route status wrong");
endmodule
bind led_slot_config_regs led_slot_config_regs_chk chk_u (.sys_clk, .rst_b, .reg_write, .reg_read, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_rvalid, .routing, .emitter3_cfg, .route_status, .emitter3_peak_target);

// ### tb/led_slot_config_regs_tb_top.sv
// Randomised register bench for the routing and third emitter bank
`timescale 1ns/1ps
module led_slot_config_regs_tb_top
   import led_slot_pkg::*;
;
   logic          sys_clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          reg_write = 1'b0;
   logic          reg_read = 1'b0;
   logic [7:0]    reg_addr = 8'h00;
   logic [15:0]   reg_wdata = 16'h0000;
   logic [15:0]   reg_rdata;
   logic          reg_rvalid;
   slot_routing_t routing;
   emitter3_cfg_t emitter3_cfg;
   route_status_t route_status;
   logic [31:0]   emitter3_peak_target;
   logic [15:0]   r14, r22, r25, got;
   integer        seed = 32'h729ff6e9;
   integer        fail_count = 0;
   integer        tests_run = 0;
   // Last entry is an unmapped address
   logic [7:0]    adr [4] = '{8'h14, 8'h22, 8'h25, 8'h3c};
   always #2 sys_clk = ~sys_clk;
   led_slot_config_regs dut_u (.sys_clk, .rst_b, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .routing, .emitter3_cfg, .route_status, .emitter3_peak_target);
   // Tenths of mA times thousandths times tenths
   function automatic logic [31:0] peak(logic [15:0] e, logic [15:0] f);
      return (32'h1f7 + 32'hc6 * e[3:0]) * (32'h2e4 + 32'h16 * f[15:11]) * (32'h4 + 32'h6 * e[13]);
   endfunction
   function automatic logic [3:0] stat(logic [3:0] b, logic [3:0] a);
      logic cb, ca;
      cb = b == 4'h1 || b == 4'h5;
      ca = a == 4'h1 || a == 4'h5;
      return {cb, ca, !cb && b != 4'h0, !ca && a != 4'h0};
   endfunction
   task automatic chk(logic [31:0] g, logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Inputs move on the falling edge only
   task automatic wr(logic [7:0] a, logic [15:0] d);
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_write = 1'b0;
      if (a == 8'h14) r14 = d & 16'h0fff;
      if (a == 8'h22) r22 = (d & 16'h207f) | 16'h1000;
      if (a == 8'h25) r25 = d;
      // Idle edge so the next strobe never rises in the step it fell
      @(negedge sys_clk);
   endtask
   // Peak lags a write by two edges, settled by the time the read returns
   task automatic check_all(logic [7:0] a);
      reg_read = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_read = 1'b0;
      got = reg_rdata;
      chk(got, a == 8'h14 ? r14 : a == 8'h22 ? r22 : a == 8'h25 ? r25 : 16'h0000);
      chk(routing, r14[11:0]);
      chk(emitter3_cfg, {r22[13], r22[6:0]});
      chk(route_status, stat(r14[11:8], r14[7:4]));
      chk(emitter3_peak_target, peak(r22, r25));
      @(negedge sys_clk);
   endtask
   task automatic do_reset;
      rst_b = 1'b0;
      r14 = 16'h0541;
      r22 = 16'h3000;
      r25 = 16'h0000;
      repeat (8) @(negedge sys_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         check_all(adr[i]);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      do_reset();
      // Reserved bits set, then the extremes of the third emitter and fine fields
      wr(8'h14, 16'hf150);
      check_all(8'h14);
      wr(8'h22, 16'hffff);
      wr(8'h25, 16'hf800);
      check_all(8'h22);
      wr(8'h22, 16'h0000);
      check_all(8'h25);
      wr(8'h3c, 16'hffff);
      check_all(8'h3c);
      for (int i = 0; i < 80; i++) begin
         wr(adr[$unsigned($random(seed)) % 4], $random(seed));
         check_all(adr[$unsigned($random(seed)) % 4]);
      end
      do_reset();
      stop_test();
   end
endmodule
